// File: rtl/wpx_ctrl.sv
// Write-protect, triple-copy and expiration command gating
// Notes on behaviour
// - Protection bits change only after three successful copies of them.
// - Protection locks its registers, all protect bits and the read-only bit.
// - Protection blocks writes only; counting goes on with the oscillator.
// - Protect bits never clear; once one is set no others may be set.
// - Expired when a protected function's alarm fires with protection set.
// - Expired with read-only bit set: only read-scratchpad, read-memory pass.
// - Expired with read-only bit clear: all memory commands rejected.
// - Identification and selection commands are always accepted on the single-wire port.
// - Once protected, oscillator enable may be set but never cleared.
// - Interval protection forces stop/start to zero and locks auto/manual.
// - Cycle-counter protection locks the transition delay select bit.
// - On the three-wire port every byte is a memory command.
// - Busy reads one during a copy, zero when it finishes.
// - Single-wire traffic opens with a long host reset and a presence reply.
// - Device is a bus slave except for alarm interrupt signalling.
// - Accepted flag stays set until the next write-scratchpad command.
// - Control byte: protect bits 0..2, read-only, oscillator, mode bits.
`timescale 1ns/1ps
`default_nettype none
module wpx_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic writeScratchCmd,
   input wire logic copyAuthOk,
   input wire logic copyByteValid,
   input wire logic [15:0] copyByteAddr,
   input wire logic [7:0] copyByteData,
   input wire logic rtcAlarm,
   input wire logic intervalAlarm,
   input wire logic cycleAlarm,
   input wire logic threeWirePort,
   input wire logic cmdValid,
   input wire logic cmdIsRom,
   input wire logic [7:0] cmdByte,
   output logic cmdAccept,
   output logic copyBusy,
   output logic authAcceptedFlag,
   output logic expired,
   output logic [7:0] ctrlByte,
   output logic memWrEn,
   output logic [15:0] memWrAddr,
   output logic [7:0] memWrData
);
   logic [7:0] ctrl_reg, ctrl_next;
   logic [2:0] pend_reg, pend_next;
   logic [1:0] cnt_reg, cnt_next;
   logic exp_reg, exp_next;
   logic accFlag_reg, accFlag_next;
   wpx_pkg::wpx_copy_t st_reg, st_next;
   logic [10:0] busyCnt_reg, busyCnt_next;
   logic wrEn_reg, wrEn_next;
   logic [15:0] wrAddr_reg, wrAddr_next;
   logic [7:0] wrData_reg, wrData_next;
   logic [2:0] prot;
   logic anyProt;
   logic isCtrl;

   function automatic logic inRange(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction

   // Byte belongs to a register window guarded by a set protect bit
   function automatic logic isLocked(input logic [15:0] a,
                                     input logic [2:0] p);
      isLocked = (p[wpx_pkg::RTC_PROT_POS] &&
                  (inRange(a, wpx_pkg::RTC_LO, wpx_pkg::RTC_HI) ||
                   inRange(a, wpx_pkg::RTCA_LO, wpx_pkg::RTCA_HI))) ||
                 (p[wpx_pkg::ITM_PROT_POS] &&
                  (inRange(a, wpx_pkg::ITM_LO, wpx_pkg::ITM_HI) ||
                   inRange(a, wpx_pkg::ITMA_LO, wpx_pkg::ITMA_HI))) ||
                 (p[wpx_pkg::CYC_PROT_POS] &&
                  (inRange(a, wpx_pkg::CYC_LO, wpx_pkg::CYC_HI) ||
                   inRange(a, wpx_pkg::CYCA_LO, wpx_pkg::CYCA_HI)));
   endfunction

   assign prot = ctrl_reg[2:0];
   assign anyProt = |prot;
   assign isCtrl = copyByteValid && (copyByteAddr == wpx_pkg::CTRL_ADDR);

   // Control byte, staging of protect bits and expiration
   always_comb begin
      ctrl_next = ctrl_reg;
      pend_next = pend_reg;
      cnt_next = cnt_reg;
      if (isCtrl) begin
         if (!anyProt) begin
            // Non-protect fields take effect on every copy
            ctrl_next[7:3] = copyByteData[7:3];
            if (copyByteData[2:0] == 3'h0) begin
               cnt_next = 2'h0;
            end else if (copyByteData[2:0] == pend_reg && cnt_reg != 2'h0) begin
               cnt_next = cnt_reg + 2'h1;
            end else begin
               pend_next = copyByteData[2:0];
               cnt_next = 2'h1;
            end
            if (cnt_next == wpx_pkg::COPIES_NEEDED) begin
               ctrl_next[2:0] = pend_next;
               cnt_next = 2'h0;
            end
         end else begin
            // Protect bits and the read-only bit stay frozen here
            ctrl_next[wpx_pkg::OSCILLATOR_POS] =
               ctrl_reg[wpx_pkg::OSCILLATOR_POS] |
               copyByteData[wpx_pkg::OSCILLATOR_POS];
            if (!prot[wpx_pkg::ITM_PROT_POS]) begin
               ctrl_next[wpx_pkg::AUTO_POS] = copyByteData[wpx_pkg::AUTO_POS];
               ctrl_next[wpx_pkg::STOP_POS] = copyByteData[wpx_pkg::STOP_POS];
            end
            if (!prot[wpx_pkg::CYC_PROT_POS]) begin
               ctrl_next[wpx_pkg::DELAY_SEL_POS] =
                  copyByteData[wpx_pkg::DELAY_SEL_POS];
            end
         end
      end
      if (ctrl_next[wpx_pkg::ITM_PROT_POS]) begin
         ctrl_next[wpx_pkg::STOP_POS] = 1'b0;
      end
      exp_next = exp_reg |
         (prot[wpx_pkg::RTC_PROT_POS] & rtcAlarm) |
         (prot[wpx_pkg::ITM_PROT_POS] & intervalAlarm) |
         (prot[wpx_pkg::CYC_PROT_POS] & cycleAlarm);
   end

   // Accepted flag: a new acceptance wins over a clear in the same cycle
   always_comb begin
      accFlag_next = accFlag_reg;
      if (writeScratchCmd) begin
         accFlag_next = 1'b0;
      end
      if (copyAuthOk) begin
         accFlag_next = 1'b1;
      end
   end

   // Copy busy timer and filtered memory writes
   always_comb begin
      st_next = st_reg;
      busyCnt_next = busyCnt_reg;
      unique case (st_reg)
         wpx_pkg::WPX_IDLE: begin
            if (copyAuthOk) begin
               st_next = wpx_pkg::WPX_BUSY;
               busyCnt_next = 11'h000;
            end
         end
         wpx_pkg::WPX_BUSY: begin
            if (busyCnt_reg == wpx_pkg::COPY_CNT_LAST) begin
               st_next = wpx_pkg::WPX_IDLE;
            end else begin
               busyCnt_next = busyCnt_reg + 11'h001;
            end
         end
      endcase
      // Bytes in protected counter and alarm windows and the control byte are dropped, the rest still land
      wrEn_next = copyByteValid && !isCtrl &&
                  !isLocked(copyByteAddr, prot);
      wrAddr_next = copyByteValid ? copyByteAddr : wrAddr_reg;
      wrData_next = copyByteValid ? copyByteData : wrData_reg;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= wpx_pkg::CTRL_RESET;
         pend_reg <= 3'h0;
         cnt_reg <= 2'h0;
         exp_reg <= 1'b0;
         accFlag_reg <= 1'b0;
         st_reg <= wpx_pkg::WPX_IDLE;
         busyCnt_reg <= 11'h000;
         wrEn_reg <= 1'b0;
         wrAddr_reg <= 16'h0000;
         wrData_reg <= 8'h00;
      end else if (clkEn) begin
         ctrl_reg <= ctrl_next;
         pend_reg <= pend_next;
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
         accFlag_reg <= accFlag_next;
         st_reg <= st_next;
         busyCnt_reg <= busyCnt_next;
         wrEn_reg <= wrEn_next;
         wrAddr_reg <= wrAddr_next;
         wrData_reg <= wrData_next;
      end
   end

   // Protection never touches the oscillator itself, so counting goes on
   assign ctrlByte = ctrl_reg;
   assign expired = exp_reg;
   assign authAcceptedFlag = accFlag_reg;
   assign copyBusy = (st_reg == wpx_pkg::WPX_BUSY);
   assign memWrEn = wrEn_reg;
   assign memWrAddr = wrAddr_reg;
   assign memWrData = wrData_reg;

   // The three-wire port carries no selection layer
   always_comb begin
      if (!cmdValid) begin
         cmdAccept = 1'b0;
      end else if (cmdIsRom && !threeWirePort) begin
         cmdAccept = 1'b1;
      end else if (!exp_reg) begin
         cmdAccept = 1'b1;
      end else if (ctrl_reg[wpx_pkg::READONLY_POS]) begin
         cmdAccept = (cmdByte == wpx_pkg::CMD_READ_SCRATCH) ||
                     (cmdByte == wpx_pkg::CMD_READ_MEM);
      end else begin
         cmdAccept = 1'b0;
      end
   end

   // All checks live on the core clock and sleep through reset
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_ctrlWrite;
      clkEn && isCtrl && !anyProt && copyByteData[2:0] != 3'h0;
   endsequence

   property p_protNeverClears;
      anyProt |=> prot == $past(prot);
   endproperty
   a_protNeverClears: assert property (p_protNeverClears)
      else $error("protect bits changed after being set");
   property p_singleCopyNoProt;
      (s_ctrlWrite and cnt_reg == 2'h0) |=> prot == 3'h0;
   endproperty
   a_singleCopyNoProt: assert property (p_singleCopyNoProt)
      else $error("protect bits set by a single copy");
   property p_thirdCopySets;
      (s_ctrlWrite and cnt_reg == 2'h2 and copyByteData[2:0] == pend_reg)
      |=> prot == $past(copyByteData[2:0]);
   endproperty
   a_thirdCopySets: assert property (p_thirdCopySets)
      else $error("third matching copy did not set protect bits");
   property p_readonlyFrozen;
      anyProt |=> ctrl_reg[wpx_pkg::READONLY_POS] ==
         $past(ctrl_reg[wpx_pkg::READONLY_POS]);
   endproperty
   a_readonlyFrozen: assert property (p_readonlyFrozen)
      else $error("read-only bit changed under protection");
   property p_oscillatorSetOnly;
      (anyProt && ctrl_reg[wpx_pkg::OSCILLATOR_POS]) |=>
         ctrl_reg[wpx_pkg::OSCILLATOR_POS];
   endproperty
   a_oscillatorSetOnly: assert property (p_oscillatorSetOnly)
      else $error("oscillator enable cleared under protection");
   property p_stopForced;
      prot[wpx_pkg::ITM_PROT_POS] |-> !ctrl_reg[wpx_pkg::STOP_POS];
   endproperty
   a_stopForced: assert property (p_stopForced)
      else $error("stop/start not forced low");
   property p_delaySelLocked;
      prot[wpx_pkg::CYC_PROT_POS] |=> ctrl_reg[wpx_pkg::DELAY_SEL_POS] ==
         $past(ctrl_reg[wpx_pkg::DELAY_SEL_POS]);
   endproperty
   a_delaySelLocked: assert property (p_delaySelLocked)
      else $error("delay select changed under protection");
   property p_expireOnAlarm;
      (clkEn && prot[wpx_pkg::RTC_PROT_POS] && rtcAlarm) |=> expired;
   endproperty
   a_expireOnAlarm: assert property (p_expireOnAlarm)
      else $error("protected alarm did not expire the device");
   property p_expiredGate;
      (expired && cmdValid && !(cmdIsRom && !threeWirePort) &&
       !ctrl_reg[wpx_pkg::READONLY_POS]) |-> !cmdAccept;
   endproperty
   a_expiredGate: assert property (p_expiredGate)
      else $error("memory command accepted after expiry");
   property p_romAlways;
      (cmdValid && cmdIsRom && !threeWirePort) |-> cmdAccept;
   endproperty
   a_romAlways: assert property (p_romAlways)
      else $error("selection command refused");
   property p_accFlagHeld;
      (clkEn && authAcceptedFlag && !writeScratchCmd) |=> authAcceptedFlag;
   endproperty
   a_accFlagHeld: assert property (p_accFlagHeld)
      else $error("accepted flag dropped without write scratchpad");
   property p_lockedNoWrite;
      (clkEn && copyByteValid && isLocked(copyByteAddr, prot)) |=> !memWrEn;
   endproperty
   a_lockedNoWrite: assert property (p_lockedNoWrite)
      else $error("protected byte written");
endmodule
`default_nettype wire

// File: include/wpx_pkg.sv
// Constants for the write-protect and expiration controller
package wpx_pkg;
   localparam logic [15:0] CTRL_ADDR = 16'h0201;
   // Protected register windows
   localparam logic [15:0] RTC_LO = 16'h0202;
   localparam logic [15:0] RTC_HI = 16'h0206;
   localparam logic [15:0] ITM_LO = 16'h0207;
   localparam logic [15:0] ITM_HI = 16'h020B;
   localparam logic [15:0] CYC_LO = 16'h020C;
   localparam logic [15:0] CYC_HI = 16'h020F;
   localparam logic [15:0] RTCA_LO = 16'h0210;
   localparam logic [15:0] RTCA_HI = 16'h0214;
   localparam logic [15:0] ITMA_LO = 16'h0215;
   localparam logic [15:0] ITMA_HI = 16'h0219;
   localparam logic [15:0] CYCA_LO = 16'h021A;
   localparam logic [15:0] CYCA_HI = 16'h021D;
   // Control byte field positions
   localparam int RTC_PROT_POS = 0;
   localparam int ITM_PROT_POS = 1;
   localparam int CYC_PROT_POS = 2;
   localparam int READONLY_POS = 3;
   localparam int OSCILLATOR_POS = 4;
   localparam int AUTO_POS = 5;
   localparam int STOP_POS = 6;
   localparam int DELAY_SEL_POS = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] COPIES_NEEDED = 2'h3;
   // Memory command codes
   localparam logic [7:0] CMD_READ_SCRATCH = 8'hAA;
   localparam logic [7:0] CMD_READ_MEM = 8'hF0;
   // Copy busy time
   localparam int CLK_PERIOD_NS = 20;
   localparam int COPY_TIME_NS = 30000;
   localparam int COPY_CYCLES = COPY_TIME_NS / CLK_PERIOD_NS;
   localparam logic [10:0] COPY_CNT_LAST = 11'(COPY_CYCLES - 1);
   typedef enum logic [0:0] {
      WPX_IDLE = 1'b0,
      WPX_BUSY = 1'b1
   } wpx_copy_t;
endpackage

// File: sim/wpx_host.sv
// Host model driving the command side of the protect controller
`timescale 1ns/1ps
`default_nettype none
module wpx_host (
   input wire logic core_clk,
   input wire logic copyBusy,
   output logic writeScratchCmd,
   output logic copyAuthOk,
   output logic copyByteValid,
   output logic [15:0] copyByteAddr,
   output logic [7:0] copyByteData,
   output logic rtcAlarm,
   output logic intervalAlarm,
   output logic cycleAlarm,
   output logic threeWirePort,
   output logic cmdValid,
   output logic cmdIsRom,
   output logic [7:0] cmdByte
);
   initial begin
      {writeScratchCmd, copyAuthOk, copyByteValid} = 3'h0;
      {rtcAlarm, intervalAlarm, cycleAlarm} = 3'h0;
      {threeWirePort, cmdValid, cmdIsRom} = 3'h0;
      copyByteAddr = 16'h0000;
      copyByteData = 8'h00;
      cmdByte = 8'h00;
   end
   // Released byte lines show the inverse, never the stale value
   task put_byte(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      copyByteValid = 1'b1;
      copyByteAddr = a;
      copyByteData = d;
      @(negedge core_clk);
      copyByteValid = 1'b0;
      copyByteAddr = ~a;
      copyByteData = ~d;
   endtask
   // Pulse the copy authorization for one cycle to set the accepted flag
   task authorize();
      @(negedge core_clk);
      copyAuthOk = 1'b1;
      @(negedge core_clk);
      copyAuthOk = 1'b0;
   endtask
   task scratch();
      @(negedge core_clk);
      writeScratchCmd = 1'b1;
      @(negedge core_clk);
      writeScratchCmd = 1'b0;
   endtask
   // Poll the busy line until it reads zero, bounded
   task wait_copy(output int n);
      n = 0;
      while (copyBusy === 1'b1 && n < 2000) begin
         n++;
         @(negedge core_clk);
      end
   endtask
   task alarm(input int which);
      @(negedge core_clk);
      {rtcAlarm, intervalAlarm, cycleAlarm} = 3'(1 << which);
      @(negedge core_clk);
      {rtcAlarm, intervalAlarm, cycleAlarm} = 3'h0;
   endtask
   // Command held until the next call so the bench can sample it
   task cmd(input logic rom, input logic three, input logic [7:0] c);
      @(negedge core_clk);
      cmdValid = 1'b1;
      cmdIsRom = rom;
      threeWirePort = three;
      cmdByte = c;
      #1;
   endtask
endmodule
`default_nettype wire

// File: sim/write_protect_expiration_ctrl_tb_top.sv
// Self-checking bench for the protect and expiration controller
`timescale 1ns/1ps
`default_nettype none
module write_protect_expiration_ctrl_tb_top;
   logic core_clk, rst_n, writeScratchCmd, copyAuthOk, copyByteValid;
   logic rtcAlarm, intervalAlarm, cycleAlarm, threeWirePort, cmdValid;
   logic cmdIsRom, cmdAccept, copyBusy, authAcceptedFlag, expired, memWrEn;
   logic [15:0] copyByteAddr, memWrAddr;
   logic [7:0] copyByteData, cmdByte, ctrlByte, memWrData;
   int miscompares = 0;
   int n_compared = 0;
   int n;

   wpx_ctrl wpx_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
      .writeScratchCmd(writeScratchCmd), .copyAuthOk(copyAuthOk),
      .copyByteValid(copyByteValid), .copyByteAddr(copyByteAddr),
      .copyByteData(copyByteData), .rtcAlarm(rtcAlarm),
      .intervalAlarm(intervalAlarm), .cycleAlarm(cycleAlarm),
      .threeWirePort(threeWirePort), .cmdValid(cmdValid),
      .cmdIsRom(cmdIsRom), .cmdByte(cmdByte), .cmdAccept(cmdAccept),
      .copyBusy(copyBusy), .authAcceptedFlag(authAcceptedFlag),
      .expired(expired), .ctrlByte(ctrlByte), .memWrEn(memWrEn),
      .memWrAddr(memWrAddr), .memWrData(memWrData));
   wpx_host wpx_host_inst (.core_clk(core_clk), .copyBusy(copyBusy),
      .writeScratchCmd(writeScratchCmd), .copyAuthOk(copyAuthOk),
      .copyByteValid(copyByteValid), .copyByteAddr(copyByteAddr),
      .copyByteData(copyByteData), .rtcAlarm(rtcAlarm),
      .intervalAlarm(intervalAlarm), .cycleAlarm(cycleAlarm),
      .threeWirePort(threeWirePort), .cmdValid(cmdValid),
      .cmdIsRom(cmdIsRom), .cmdByte(cmdByte));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task report_and_stop();
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task do_reset();
      rst_n = 1'b0;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
   endtask
   // One full copy of a control byte, waiting out the busy time
   task ctrl_copy(input logic [7:0] v, input logic [7:0] e);
      wpx_host_inst.authorize();
      chk("authAcceptedFlag", 16'h1, 16'(authAcceptedFlag));
      wpx_host_inst.put_byte(wpx_pkg::CTRL_ADDR, v);
      chk("ctrlByte", 16'(e), 16'(ctrlByte));
      // Two of the busy cycles pass while the byte is being placed
      wpx_host_inst.wait_copy(n);
      chk("busyCycles", 16'(wpx_pkg::COPY_CYCLES - 2), 16'(n));
   endtask
   task t_plain();
      chk("ctrlByte", 16'h0000, 16'(ctrlByte));
      wpx_host_inst.put_byte(16'h0030, 8'hA5);
      chk("memWrEn", 16'h1, 16'(memWrEn));
      chk("memWrAddr", 16'h0030, memWrAddr);
      chk("memWrData", 16'h00A5, 16'(memWrData));
      @(negedge core_clk);
      chk("memWrEn", 16'h0, 16'(memWrEn));
   endtask
   // Stop/start is forced low as the interval bit lands
   task t_triple();
      ctrl_copy(8'h53, 8'h50);
      ctrl_copy(8'h53, 8'h50);
      ctrl_copy(8'h53, 8'h13);
   endtask
   task t_locked();
      wpx_host_inst.put_byte(wpx_pkg::CTRL_ADDR, 8'h6C);
      chk("ctrlByte", 16'h0013, 16'(ctrlByte));
      wpx_host_inst.put_byte(16'h0203, 8'h11);
      chk("memWrEn", 16'h0, 16'(memWrEn));
      wpx_host_inst.put_byte(16'h0216, 8'h22);
      chk("memWrEn", 16'h0, 16'(memWrEn));
      wpx_host_inst.put_byte(16'h020C, 8'h33);
      chk("memWrEn", 16'h1, 16'(memWrEn));
   endtask
   task t_flag();
      wpx_host_inst.scratch();
      chk("authAcceptedFlag", 16'h0, 16'(authAcceptedFlag));
      wpx_host_inst.authorize();
      chk("authAcceptedFlag", 16'h1, 16'(authAcceptedFlag));
      wpx_host_inst.scratch();
      chk("authAcceptedFlag", 16'h0, 16'(authAcceptedFlag));
      wpx_host_inst.wait_copy(n);
      chk("busyCycles", 16'(wpx_pkg::COPY_CYCLES - 2), 16'(n));
   endtask
   task t_expire();
      logic [7:0] codes [4];
      codes = '{8'hAA, 8'hF0, 8'h0F, 8'h55};
      wpx_host_inst.cmd(1'b0, 1'b0, 8'h55);
      chk("cmdAccept", 16'h1, 16'(cmdAccept));
      wpx_host_inst.alarm(0);
      chk("expired", 16'h0, 16'(expired));
      wpx_host_inst.alarm(2);
      chk("expired", 16'h1, 16'(expired));
      foreach (codes[i]) begin
         wpx_host_inst.cmd(1'b0, 1'b0, codes[i]);
         chk("cmdAccept", 16'h0, 16'(cmdAccept));
      end
      wpx_host_inst.cmd(1'b1, 1'b0, 8'hCC);
      chk("cmdAccept", 16'h1, 16'(cmdAccept));
      wpx_host_inst.cmd(1'b1, 1'b1, 8'hCC);
      chk("cmdAccept", 16'h0, 16'(cmdAccept));
   endtask
   task t_readonly();
      logic [7:0] codes [4];
      codes = '{8'hAA, 8'hF0, 8'h0F, 8'h55};
      do_reset();
      repeat (2) ctrl_copy(8'h0C, 8'h08);
      ctrl_copy(8'h0C, 8'h0C);
      wpx_host_inst.put_byte(wpx_pkg::CTRL_ADDR, 8'h9C);
      chk("ctrlByte", 16'h001C, 16'(ctrlByte));
      wpx_host_inst.alarm(0);
      chk("expired", 16'h1, 16'(expired));
      foreach (codes[i]) begin
         wpx_host_inst.cmd(1'b0, 1'b1, codes[i]);
         chk("cmdAccept", 16'(i < 2), 16'(cmdAccept));
      end
   endtask

   initial begin
      do_reset();
      t_plain();
      t_triple();
      t_locked();
      t_flag();
      t_expire();
      t_readonly();
      report_and_stop();
   end
   // Seven copies of 1500 cycles dominate the run
   initial begin
      #(20 * 20000);
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
